// *** rtl/pacl_adc_ctrl.sv ***
// control logic around an eight-input 12-bit converter core
`timescale 1ns/100ps
module pacl_adc_ctrl (
  input  wire logic                           clk_sys,
  input  wire logic                           reset_n,
  input  wire logic                           convClkEn,
  input  wire pacl_pkg::pacl_mode_t           mode,
  input  wire logic                           startWrite,
  input  wire logic [pacl_pkg::NUM_CH-1:0]    channelEnableWrite,
  input  wire logic [pacl_pkg::NUM_CH-1:0]    channelDisableWrite,
  input  wire logic                           extTriggerPin,
  input  wire logic [2:0]                     timerTrig,
  input  wire logic [1:0]                     pwmEvent,
  input  wire logic [pacl_pkg::RES_W-1:0]     coreResult,
  input  wire logic                           channelResultRead,
  input  wire logic [pacl_pkg::CH_W-1:0]      channelResultSel,
  input  wire logic                           lastResultRead,
  input  wire logic                           statusRead,
  input  wire logic                           dmaEnable,
  input  wire logic                           dmaReady,
  output pacl_pkg::pacl_core_ctrl_t           coreCtrl,
  output logic [pacl_pkg::NUM_CH-1:0]         channelEnabled,
  output pacl_pkg::pacl_status_t              status,
  output logic [pacl_pkg::RES_W-1:0]          channelResultReg,
  output logic [pacl_pkg::RES_W-1:0]          lastResultField,
  output logic [pacl_pkg::CH_W-1:0]           lastResultChannel,
  output logic                                busy,
  output logic                                dmaValid,
  output logic [pacl_pkg::DMA_W-1:0]          dmaData
);
  import pacl_pkg::*;

  pacl_state_t       state_r, state_nxt;
  logic [CH_W-1:0]   curCh_r, curCh_nxt;
  logic [CNT_W-1:0]  cnt_r, cnt_nxt;
  logic [PRE_W-1:0]  preCnt_r, preCnt_nxt;
  logic [PRE_W-1:0]  divMax;
  logic              adcTick;
  logic [NUM_CH-1:0] chanEn_r, chanEn_nxt;
  logic [NUM_CH-1:0] activeMask;
  logic [TRG_N-1:0]  trgSrc, trgSync1_r, trgSync2_r, trgPrev_r;
  logic              hwRise, trigger;
  logic              firstFound, nextFound;
  logic [CH_W-1:0]   firstCh, nextCh;
  logic [RES_W-1:0]  result;
  logic              bufInReady, storeFire;
  logic [RES_W-1:0]  chanData_r [NUM_CH];
  logic [RES_W-1:0]  chanData_nxt [NUM_CH];
  logic [RES_W-1:0]  lastData_r, lastData_nxt;
  logic [CH_W-1:0]   lastCh_r, lastCh_nxt;
  logic [RES_W-1:0]  chanRd_r, chanRd_nxt;
  pacl_status_t      stat_r, stat_nxt;

  // lowest set bit of a mask strictly above a given channel
  function automatic logic [CH_W:0] pick(input logic [NUM_CH-1:0] m,
                                         input logic [CH_W-1:0] after,
                                         input logic fromZero);
    logic [CH_W:0] res;
    res = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (m[i] && (fromZero || (CH_W'(i) > after))) begin
        res = {1'b1, CH_W'(i)};
      end
    end
    return res;
  endfunction

  // prescaler: period is 2*(sel+1) master cycles
  assign divMax  = {mode.clockDividerSel, 1'b1};
  assign adcTick = convClkEn && (preCnt_r == divMax);

  always_comb begin
    preCnt_nxt = preCnt_r + 1'b1;
    if (!convClkEn || adcTick) begin
      preCnt_nxt = '0;
    end
  end

  // enable and disable writes act per bit, disable wins
  always_comb begin
    chanEn_nxt = (chanEn_r | channelEnableWrite) & ~channelDisableWrite;
  end

  // hardware trigger sources arrive from other logic or a pin
  assign trgSrc = {pwmEvent, timerTrig, extTriggerPin};

  // two flops per source before any logic sees it
  genvar g;
  generate
    for (g = 0; g < TRG_N; g++) begin : gSync
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          trgSync1_r[g] <= 1'b0;
          trgSync2_r[g] <= 1'b0;
          trgPrev_r[g]  <= 1'b0;
        end else begin
          trgSync1_r[g] <= trgSrc[g];
          trgSync2_r[g] <= trgSync1_r[g];
          trgPrev_r[g]  <= trgSync2_r[g];
        end
      end
    end
  endgenerate

  // rising edge of the chosen source, start write
  assign hwRise  = (int'(mode.trigSel) < TRG_N) &&
                   trgSync2_r[mode.trigSel] && !trgPrev_r[mode.trigSel];
  assign trigger = startWrite || (mode.hwTrigEn && hwRise);

  // differential mode scans even channels only
  assign activeMask = mode.differentialSel ? (chanEn_r & DIFFERENTIAL_SEL_CH_MASK)
                                           : chanEn_r;
  assign {firstFound, firstCh} = pick(activeMask, '0, 1'b1);
  assign {nextFound, nextCh}   = pick(activeMask, curCh_r, 1'b0);

  // reduced results keep the upper ten bits, top reads zero
  assign result = mode.reducedResolutionSel ?
                  {{LOW_DROP{1'b0}}, coreResult[RES_W-1:LOW_DROP]} :
                  coreResult;

  // a full dma buffer holds the sequencer in store
  assign storeFire = (state_r == ST_STORE) && (!dmaEnable || bufInReady);

  // sequencer: later triggers are ignored until idle again
  always_comb begin
    state_nxt = state_r;
    curCh_nxt = curCh_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      ST_IDLE: begin
        // idle until the converter clock runs
        if (trigger && firstFound && convClkEn) begin
          state_nxt = ST_SAMPLE;
          curCh_nxt = firstCh;
          cnt_nxt   = '0;
        end
      end
      ST_SAMPLE: begin
        if (cnt_r == CNT_W'(mode.sampleHoldCycles)) begin
          state_nxt = ST_CONVERT;
          cnt_nxt   = '0;
        end else if (adcTick) begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      ST_CONVERT: begin
        if (cnt_r == CONV_CYCLES) begin
          state_nxt = ST_STORE;
        end else if (adcTick) begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      ST_STORE: begin
        // next enabled channel upward, else back to idle
        if (storeFire) begin
          cnt_nxt = '0;
          if (nextFound) begin
            state_nxt = ST_SAMPLE;
            curCh_nxt = nextCh;
          end else begin
            state_nxt = ST_IDLE;
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // result registers, flags and read captures
  always_comb begin
    chanData_nxt = chanData_r;
    lastData_nxt = lastData_r;
    lastCh_nxt   = lastCh_r;
    chanRd_nxt   = chanRd_r;
    stat_nxt     = stat_r;
    // reads clear first so a same-cycle completion wins
    if (channelResultRead) begin
      chanRd_nxt = chanData_r[channelResultSel];
      stat_nxt.done[channelResultSel] = 1'b0;
    end
    if (lastResultRead) begin
      stat_nxt.resultReady  = 1'b0;
      stat_nxt.done[lastCh_r] = 1'b0;
    end
    // status read clears both overrun kinds
    if (statusRead) begin
      stat_nxt.channelOverrun = '0;
      stat_nxt.anyOverrun     = 1'b0;
    end
    if (storeFire) begin
      // same value to channel and shared registers
      chanData_nxt[curCh_r] = result;
      lastData_nxt          = result;
      lastCh_nxt            = curCh_r;
      if (stat_r.done[curCh_r]) begin
        stat_nxt.channelOverrun[curCh_r] = 1'b1;
      end
      if (stat_r.resultReady) begin
        stat_nxt.anyOverrun = 1'b1;
      end
      stat_nxt.done[curCh_r] = 1'b1;
      stat_nxt.resultReady   = 1'b1;
    end
  end

  // control and data registers start cleared
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_r    <= ST_IDLE;
      curCh_r    <= '0;
      cnt_r      <= '0;
      preCnt_r   <= '0;
      chanEn_r   <= '0;
      lastData_r <= '0;
      lastCh_r   <= '0;
      chanRd_r   <= '0;
      stat_r     <= '0;
      for (int i = 0; i < NUM_CH; i++) begin
        chanData_r[i] <= '0;
      end
    end else begin
      state_r    <= state_nxt;
      curCh_r    <= curCh_nxt;
      cnt_r      <= cnt_nxt;
      preCnt_r   <= preCnt_nxt;
      chanEn_r   <= chanEn_nxt;
      lastData_r <= lastData_nxt;
      lastCh_r   <= lastCh_nxt;
      chanRd_r   <= chanRd_nxt;
      stat_r     <= stat_nxt;
      for (int i = 0; i < NUM_CH; i++) begin
        chanData_r[i] <= chanData_nxt[i];
      end
    end
  end

  // every dma word zero-extended to 16 bits
  pacl_pair_buf #(
    .WIDTH (DMA_W),
    .DEPTH (BUF_DEPTH)
  ) uBuf (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .inValid  ((state_r == ST_STORE) && dmaEnable),
    .inReady  (bufInReady),
    .inData   ({{(DMA_W-RES_W){1'b0}}, result}),
    .outValid (dmaValid),
    .outReady (dmaReady),
    .outData  (dmaData)
  );

  // pins shared; unenabled core inputs stay grounded
  assign coreCtrl.inputConnect = chanEn_r;
  assign coreCtrl.muxChannel   = curCh_r;
  assign coreCtrl.diffMode     = mode.differentialSel;
  assign coreCtrl.sampling     = (state_r == ST_SAMPLE);
  assign coreCtrl.converting   = (state_r == ST_CONVERT);

  assign channelEnabled    = chanEn_r;
  assign status            = stat_r;
  assign channelResultReg  = chanRd_r;
  assign lastResultField   = lastData_r;
  assign lastResultChannel = lastCh_r;
  assign busy              = (state_r != ST_IDLE);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // store only after ten converter ticks
  property p_conv_len;
    $rose(state_r == ST_STORE) |-> $past(cnt_r) == CONV_CYCLES;
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("store reached before ten converter ticks");

  // divider restarts after every tick
  property p_div;
    adcTick |=> preCnt_r == '0;
  endproperty
  a_div: assert property (p_div)
    else $error("prescaler did not restart after tick");

  // reduced mode clears top result bits
  property p_reduced_resolution_sel;
    storeFire && mode.reducedResolutionSel |=>
      lastData_r[RES_W-1 -: LOW_DROP] == '0;
  endproperty
  a_reduced_resolution_sel: assert property (p_reduced_resolution_sel)
    else $error("reduced result has upper bits set");

  property p_dma_w;
    dmaValid |-> dmaData[DMA_W-1:RES_W] == '0;
  endproperty
  a_dma_w: assert property (p_dma_w)
    else $error("dma word wider than result");

  // differential scan stays on even channels
  property p_differential_sel;
    mode.differentialSel && $rose(state_r == ST_SAMPLE) |->
      curCh_r[0] == 1'b0;
  endproperty
  a_differential_sel: assert property (p_differential_sel)
    else $error("odd channel converted in differential mode");

  // accepted trigger starts sampling next cycle
  property p_trig;
    state_r == ST_IDLE && trigger && firstFound && convClkEn |=>
      state_r == ST_SAMPLE && curCh_r == $past(firstCh);
  endproperty
  a_trig: assert property (p_trig)
    else $error("trigger did not start a sequence");

  property p_both;
    storeFire |=> chanData_r[lastCh_r] == lastData_r;
  endproperty
  a_both: assert property (p_both)
    else $error("channel and last result differ");

  property p_ready;
    storeFire |=> stat_r.resultReady && stat_r.done[$past(curCh_r)];
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready or done not set on completion");

  // overwrite of unread result flags overrun
  property p_ovr;
    storeFire && stat_r.resultReady |=> stat_r.anyOverrun;
  endproperty
  a_ovr: assert property (p_ovr)
    else $error("global overrun missed");
endmodule

// *** rtl/pacl_pkg.sv ***
// shared constants and types for the converter control logic
package pacl_pkg;
  localparam int NUM_CH    = 8;
  localparam int CH_W      = 3;
  localparam int RES_W     = 12;
  localparam int LOW_DROP  = 2;
  localparam int DMA_W     = 16;
  localparam int DIV_W     = 6;
  localparam int PRE_W     = 7;
  localparam int SH_W      = 4;
  localparam int CNT_W     = 5;
  localparam int TRG_N     = 6;
  localparam int BUF_DEPTH = 2;

  // converter clock cycles after sample-and-hold
  localparam logic [CNT_W-1:0]  CONV_CYCLES  = 5'h0A;
  // differential mode keeps only channels 0, 2, 4 and 6
  localparam logic [NUM_CH-1:0] DIFFERENTIAL_SEL_CH_MASK = 8'h55;

  typedef enum logic [2:0] {
    TRG_EXT  = 3'b000,
    TRG_TIO0 = 3'b001,
    TRG_TIO1 = 3'b010,
    TRG_TIO2 = 3'b011,
    TRG_PWM0 = 3'b100,
    TRG_PWM1 = 3'b101
  } pacl_trig_sel_t;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_SAMPLE  = 2'b01,
    ST_CONVERT = 2'b10,
    ST_STORE   = 2'b11
  } pacl_state_t;

  typedef struct packed {
    logic [DIV_W-1:0] clockDividerSel;
    logic [SH_W-1:0]  sampleHoldCycles;
    logic             reducedResolutionSel;
    logic             differentialSel;
    logic             hwTrigEn;
    pacl_trig_sel_t   trigSel;
  } pacl_mode_t;

  typedef struct packed {
    logic [NUM_CH-1:0] inputConnect;
    logic [CH_W-1:0]   muxChannel;
    logic              diffMode;
    logic              sampling;
    logic              converting;
  } pacl_core_ctrl_t;

  typedef struct packed {
    logic [NUM_CH-1:0] done;
    logic [NUM_CH-1:0] channelOverrun;
    logic              resultReady;
    logic              anyOverrun;
  } pacl_status_t;
endpackage

// *** rtl/pacl_pair_buf.sv ***
// small first-in first-out buffer with valid/ready on both sides
`timescale 1ns/100ps
module pacl_pair_buf #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0]    wrPtr_r, wrPtr_nxt;
  logic [PW-1:0]    rdPtr_r, rdPtr_nxt;
  logic [PW:0]      count_r, count_nxt;
  logic             push, pop;

  // honest flags straight from the fill count
  assign inReady  = (count_r < (PW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData  = mem_r[rdPtr_r];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // pointer and count update, wrapping at depth
  always_comb begin
    wrPtr_nxt = wrPtr_r;
    rdPtr_nxt = rdPtr_r;
    count_nxt = count_r;
    if (push) begin
      wrPtr_nxt = (wrPtr_r == PW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
    end
    if (pop) begin
      rdPtr_nxt = (rdPtr_r == PW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;
    end
    if (push && !pop) begin
      count_nxt = count_r + 1'b1;
    end else if (pop && !push) begin
      count_nxt = count_r - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      count_r <= count_nxt;
    end
  end

  // storage needs no reset; valid gates every read
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_r[wrPtr_r] <= inData;
    end
  end
endmodule

// *** verif/pacl_core_model.sv ***
// behavioural far side: analogue core result and dma sink
`timescale 1ns/100ps
module pacl_core_model (
  input  wire logic                      clk_sys,
  input  wire logic                      reset_n,
  input  wire pacl_pkg::pacl_core_ctrl_t coreCtrl,
  input  wire logic                      busy,
  input  wire logic                      stall,
  output logic [pacl_pkg::RES_W-1:0]     coreResult,
  output logic                           dmaReady
);
  import pacl_pkg::*;
  logic [CH_W-1:0]  ch;
  logic [RES_W-1:0] noise_r;
  logic             storing;

  assign ch      = coreCtrl.muxChannel;
  assign storing = busy && !coreCtrl.sampling && !coreCtrl.converting;

  // outside the store cycle the output wanders, so a stale grab shows
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      noise_r <= 12'h000;
    end else begin
      noise_r <= noise_r + 12'h3A7;
    end
  end

  // word names the muxed channel
  // an input that is not connected only shows noise
  assign coreResult = (storing && coreCtrl.inputConnect[ch]) ?
                      {ch, 6'h2D, ~ch} : noise_r;
  assign dmaReady   = !stall;
endmodule

// *** verif/tb_pipeline_adc_control_logic.sv ***
// self-checking bench for the converter control logic
`timescale 1ns/100ps
module tb_pipeline_adc_control_logic;
  import pacl_pkg::*;
  logic            clk_sys = 0, reset_n = 0, convClkEn = 0;
  logic            startWrite = 0, chanRd = 0, lastRd = 0, statRd = 0;
  logic            dmaEnable = 0, stall = 0, dmaReady, busy, dmaValid;
  pacl_mode_t      mode = '0;
  logic [7:0]      chEnW = 0, chDisW = 0, chEn, mask, m;
  logic [5:0]      trg = 0;
  logic [2:0]      chSel = 0, lastCh, last;
  logic [11:0]     coreResult, chRes, lastRes;
  logic [15:0]     dmaData;
  logic [15:0]     gotQ[$];
  pacl_core_ctrl_t coreCtrl;
  pacl_status_t    status;
  int              seed = 72221, bad_count = 0, compares = 0;
  int              div = 0, cnvCnt = 0, c, ch, k, i, s;

  always #2.5 clk_sys = ~clk_sys;

  pacl_adc_ctrl dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .convClkEn(convClkEn), .mode(mode), .startWrite(startWrite),
    .channelEnableWrite(chEnW), .channelDisableWrite(chDisW),
    .extTriggerPin(trg[0]), .timerTrig(trg[3:1]), .pwmEvent(trg[5:4]),
    .coreResult(coreResult), .channelResultRead(chanRd),
    .channelResultSel(chSel), .lastResultRead(lastRd),
    .statusRead(statRd), .dmaEnable(dmaEnable), .dmaReady(dmaReady),
    .coreCtrl(coreCtrl), .channelEnabled(chEn), .status(status),
    .channelResultReg(chRes), .lastResultField(lastRes),
    .lastResultChannel(lastCh), .busy(busy), .dmaValid(dmaValid),
    .dmaData(dmaData));

  pacl_core_model partner (.clk_sys(clk_sys), .reset_n(reset_n),
    .coreCtrl(coreCtrl), .busy(busy), .stall(stall),
    .coreResult(coreResult), .dmaReady(dmaReady));

  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  function automatic logic [15:0] expW(logic [2:0] cn, logic lo);
    logic [11:0] r;
    r = {cn, 6'h2D, ~cn};
    return lo ? {6'h00, r[11:2]} : {4'h0, r};
  endfunction

  task automatic cyc(int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // bounded wait for idle; a stalled sink is let go part way
  task automatic waitIdle();
    for (i = 0; i < 40000; i++) begin
      @(posedge clk_sys);
      if (i == 3000) stall <= 0;
      #1;
      if (i > 1 && busy === 1'b0) break;
    end
    if (i == 40000) begin
      chk("idleWait", 0, 1);
      end_of_test();
    end
    cyc(6);
  endtask

  task automatic go();
    cyc(1);
    startWrite <= 1;
    cyc(1);
    startWrite <= 0;
    cyc(2);
    // a second start while busy must not add words
    startWrite <= 1;
    cyc(1);
    startWrite <= 0;
    waitIdle();
  endtask

  task automatic rd(int kind, logic [2:0] cn);
    cyc(1);
    chSel <= cn;
    chanRd <= (kind == 0);
    lastRd <= (kind == 1);
    statRd <= (kind == 2);
    cyc(1);
    chanRd <= 0;
    lastRd <= 0;
    statRd <= 0;
    cyc(1);
    #1;
  endtask

  // length of every conversion phase, counted in system cycles
  // sampled on the falling edge, where outputs have settled
  always @(negedge clk_sys) begin
    if (coreCtrl.converting === 1'b1) cnvCnt <= cnvCnt + 1;
    else if (cnvCnt != 0) begin
      chk("convCycles", cnvCnt, 20 * (div + 1));
      cnvCnt <= 0;
    end
  end

  // words taken by the sink, in arrival order
  always @(negedge clk_sys) begin
    if (dmaValid === 1'b1 && dmaReady === 1'b1) gotQ.push_back(dmaData);
  end

  initial begin
    cyc(4);
    #1;
    chk("rstStatus", status, 0);
    chk("rstEn", chEn, 0);
    chk("rstConnect", coreCtrl.inputConnect, 0);
    chk("rstDiff", coreCtrl.diffMode, 0);
    chk("rstBusy", busy, 0);
    cyc(1);
    reset_n <= 1;
    // resolution and input type in every combination
    for (c = 0; c < 4; c++) begin
      div = (c == 2) ? 63 : (c == 3) ? ($random(seed) & 8'h3F) : c;
      mask = $random(seed) | ((c == 1) ? 8'h15 : 8'h01);
      m = mask & (c[0] ? DIFFERENTIAL_SEL_CH_MASK : 8'hFF);
      cyc(1);
      convClkEn <= 0;
      mode.clockDividerSel <= div[5:0];
      mode.sampleHoldCycles <= 4'h1 + (($random(seed) & 8'h0F) % 15);
      mode.reducedResolutionSel <= c[1];
      mode.differentialSel <= c[0];
      chDisW <= 8'hFF;
      cyc(1);
      chDisW <= 8'h00;
      chEnW <= mask;
      cyc(1);
      chEnW <= 8'h00;
      startWrite <= 1;
      cyc(1);
      startWrite <= 0;
      cyc(4);
      #1;
      chk("gatedBusy", busy, 0);
      chk("chEn", chEn, mask);
      chk("connect", coreCtrl.inputConnect, mask);
      chk("diffMode", coreCtrl.diffMode, c[0]);
      cyc(1);
      convClkEn <= 1;
      stall <= (c == 1);
      dmaEnable <= 1;
      gotQ.delete();
      go();
      k = 0;
      for (ch = 0; ch < 8; ch++) begin
        if (m[ch]) begin
          chk("dmaWord", gotQ[k], expW(ch, c[1]));
          k++;
          last = ch;
        end
      end
      chk("dmaCount", gotQ.size(), k);
      chk("done", status.done, m);
      chk("ready", status.resultReady, 1);
      chk("lastRes", lastRes, expW(last, c[1]));
      chk("lastCh", lastCh, last);
      go();
      chk("ovr", status.channelOverrun, m);
      chk("anyOvr", status.anyOverrun, 1);
      rd(2, 0);
      chk("ovrClr", status.channelOverrun, 0);
      chk("anyOvrClr", status.anyOverrun, 0);
      rd(1, 0);
      chk("readyClr", status.resultReady, 0);
      chk("lastDoneClr", status.done[last], 0);
      for (ch = 0; ch < 8; ch++) begin
        if (m[ch]) begin
          rd(0, ch);
          chk("chRes", chRes, expW(ch, c[1]));
          chk("doneClr", status.done[ch], 0);
        end
      end
    end
    // each hardware source, with a foreign edge ignored first
    cyc(1);
    mode.hwTrigEn <= 1;
    mode.clockDividerSel <= 6'h00;
    dmaEnable <= 0;
    gotQ.delete();
    div = 0;
    for (s = 0; s < 6; s++) begin
      cyc(1);
      mode.trigSel <= pacl_trig_sel_t'(s);
      cyc(2);
      trg <= 6'h01 << ((s + 1) % 6);
      cyc(2);
      trg <= 6'h00;
      cyc(8);
      #1;
      chk("foreignSrc", busy, 0);
      cyc(1);
      trg <= 6'h01 << s;
      cyc(2);
      trg <= 6'h00;
      for (k = 0; k < 12 && busy !== 1'b1; k++) begin
        cyc(1);
        #1;
      end
      chk("hwStart", busy, 1);
      waitIdle();
    end
    // unused select code 6 starts nothing
    cyc(1);
    mode.trigSel <= pacl_trig_sel_t'(3'h6);
    cyc(2);
    trg <= 6'h3F;
    cyc(2);
    trg <= 6'h00;
    cyc(8);
    #1;
    chk("noSrc", busy, 0);
    chk("noDma", gotQ.size(), 0);
    cyc(1);
    chDisW <= 8'hFF;
    chEnW <= 8'hFF;
    cyc(1);
    chDisW <= 8'h00;
    chEnW <= 8'h00;
    cyc(1);
    #1;
    chk("disEn", chEn, 0);
    chk("disConnect", coreCtrl.inputConnect, 0);
    end_of_test();
  end
endmodule
